/* pgf_gpio.sv */
// How it works
// - Four pins: input, push-pull, open-drain, analog (pins 1-3 only)
// - Output value from register bit or PWM
// - Polarity bit inverts input and output
// - Input level readable, output bit drives pin
// - Input pins switch selected regulators on/off
// - Interrupt output high while request pending
// - Supply-low output when below threshold, enable off
// - Either pin edge sets pin-interrupt flag
// - Dimming pin gates sinks with control 11b
// - Voltage select: low pin uses alternate setting
// - Code 5 pin to select-field mapping
// - Code 6 adds stand-by on low pin
// - Power-good output after start-up completes
// - Clock output: crystal, else RC clock
// - Rising pin edge triggers the watchdog
// - Over-current output from first boost converter
// - One PWM generator routable to outputs
// - Request when any enabled flag set
// - Read captures flags, clears sent bits after
// - Clear takes 3 cycles, reads zero meanwhile
// - Request released during flag reads
// - Windowed watchdog with enable and reset enable
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module pgf_gpio #(
  parameter int DOG_TICK = pgf_pkg::DOG_TICK_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pgf_pkg::pgf_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic [pgf_pkg::NPIN-1:0] pad_i,
  output logic [pgf_pkg::NPIN-1:0] pad_o,
  output logic [pgf_pkg::NPIN-1:0] pad_oe_n_o,
  output logic [pgf_pkg::NPIN-1:0] pull_up_o,
  output logic [pgf_pkg::NPIN-1:0] pull_down_o,
  output logic [pgf_pkg::NPIN-1:0] analog_en_o,
  input wire logic [23:0] irq_event_i,
  input wire logic supply_fall_threshold_i,
  input wire logic startup_done_i,
  input wire logic xtal_clk_i,
  input wire logic xtal_ok_i,
  input wire logic rc_clk_i,
  input wire logic first_boost_converter_oc_i,
  output logic [pgf_pkg::NREG-1:0] reg_pin_ctrl_o,
  output logic [pgf_pkg::NREG-1:0] reg_pin_on_o,
  output logic [pgf_pkg::NSINK-1:0] sink_on_o,
  output logic [pgf_pkg::NSINK-1:0][7:0] sink_current_level_o,
  output logic [pgf_pkg::NSEL-1:0] alt_active_o,
  output logic [pgf_pkg::NSEL-1:0][3:0] alternate_regulator_choice_o,
  output logic [pgf_pkg::NSEL-1:0][6:0] alternate_voltage_setting_o,
  output logic standby_req_o,
  output logic dog_expired_o,
  output logic dog_reset_req_o
);
  import pgf_pkg::*;

  typedef struct packed {
    pgf_pin_cfg_t [NPIN-1:0] cfg;
    logic [NPIN-1:0] pull_up;
    logic [NPIN-1:0] pull_down;
    logic [NPIN-1:0] drive;
    logic [NREG-1:0][2:0] onoff_sel;
    logic [NSINK-1:0][1:0] sink_ctrl;
    logic [NSINK-1:0][7:0] sink_cur;
    logic [NSEL-1:0][3:0] alt_choice;
    logic [NSEL-1:0][6:0] alt_volt;
    logic supply_reset_enable;
    logic dog_en;
    logic dog_rst_en;
    logic [7:0] dog_min;
    logic [7:0] dog_max;
    logic [7:0] pwm_h;
    logic [7:0] pwm_l;
    logic [7:0] pwm_div;
    logic [NFLAG-1:0][7:0] flag;
    logic [NFLAG-1:0][7:0] mask;
    logic [NFLAG-1:0][7:0] cap;
    logic [NFLAG-1:0][1:0] clr_cnt;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] lvl_prev;
    pgf_dog_st_t dog_st;
    logic [31:0] dog_pre;
    logic [7:0] dog_cnt;
    logic dog_exp;
    logic dog_rst;
    logic [7:0] rdata;
    logic [NPIN-1:0] pad_out;
    logic [NPIN-1:0] pad_oe_n;
    logic [NPIN-1:0] ana;
    logic [NREG-1:0] reg_ctrl;
    logic [NREG-1:0] reg_on;
    logic [NSINK-1:0] sink_on;
    logic [NSEL-1:0] alt;
    logic standby;
  } pgf_gpio_st_t;

  pgf_gpio_st_t s_reg, s_next;
  logic pwm;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] edge_seen;
  logic [NFLAG-1:0][7:0] set_ev;
  logic flag_rd;
  logic hold;
  logic irq;
  logic dog_trig;
  logic dim;
  logic [7:0] idx;
  logic [NPIN-1:0] val;

  // ----------------------------------------
  // PWM generator
  // ----------------------------------------
  // single PWM source
  pgf_pwm #(
    .W(8)
  ) u_pwm (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .high_i(s_reg.pwm_h),
    .low_i(s_reg.pwm_l),
    .div_i(s_reg.pwm_div),
    .pwm_o(pwm)
  );

  // Alternate-setting request for one function code
  function automatic logic [NSEL-1:0] vsel_map(
    input logic [3:0] code,
    input logic [NPIN-1:0] l,
    input pgf_pin_cfg_t [NPIN-1:0] c
  );
    logic both;
    logic [NSEL-1:0] m;
    both = (c[0].func == code) && (c[1].func == code);
    m = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (c[p].func == code && !l[p]) begin
        if (p >= 2 || !both) begin
          m = '1;
        end else begin
          m[p] = 1'b1;
        end
      end
    end
    return m;
  endfunction : vsel_map

  always_comb begin
    s_next = s_reg;
    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    // two-stage synchroniser
    s_next.sync1 = pad_i;
    s_next.sync2 = s_reg.sync1;
    for (int p = 0; p < NPIN; p++) begin
      lvl[p] = s_reg.sync2[p] ^ s_reg.cfg[p].invert;
    end
    s_next.lvl_prev = lvl;
    edge_seen = lvl ^ s_reg.lvl_prev;

    // ----------------------------------------
    // Interrupt flags
    // ----------------------------------------
    set_ev = irq_event_i;
    for (int p = 0; p < NPIN; p++) begin
      if (s_reg.cfg[p].func == FN_IRQ_IN && edge_seen[p]) begin
        set_ev[0][0] = 1'b1;
      end
    end
    set_ev[0][1] = set_ev[0][1] | s_reg.dog_exp;
    flag_rd = bus_i.rd && bus_i.addr >= A_FLAG && bus_i.addr < A_FLAG + 8'(NFLAG);
    hold = flag_rd;
    for (int k = 0; k < NFLAG; k++) begin
      if (s_reg.clr_cnt[k] != 2'h0) begin
        hold = 1'b1;
        s_next.clr_cnt[k] = s_reg.clr_cnt[k] - 2'h1;
      end
      // Set wins over clear outside the clearing step
      s_next.flag[k] = s_reg.flag[k] | set_ev[k];
      if (s_reg.clr_cnt[k] == 2'h1) begin
        s_next.flag[k] = (s_reg.flag[k] | set_ev[k]) & ~s_reg.cap[k];
      end
    end
    irq = (|(s_reg.flag & s_reg.mask)) && !hold;

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    s_next.rdata = 8'h00;
    dog_trig = 1'b0;
    idx = 8'h00;
    if (bus_i.wr) begin
      if (bus_i.addr >= A_CFG && bus_i.addr < A_CFG + 8'(NPIN)) begin
        idx = bus_i.addr - A_CFG;
        s_next.cfg[idx[1:0]] = bus_i.wdata;
      end else if (bus_i.addr == A_PULL) begin
        s_next.pull_up = bus_i.wdata[3:0];
        s_next.pull_down = bus_i.wdata[7:4];
      end else if (bus_i.addr == A_DRIVE) begin
        s_next.drive = bus_i.wdata[3:0];
      end else if (bus_i.addr == A_CTRL) begin
        s_next.supply_reset_enable = bus_i.wdata[0];
        s_next.dog_en = bus_i.wdata[1];
        s_next.dog_rst_en = bus_i.wdata[2];
      end else if (bus_i.addr == A_DOGMIN) begin
        s_next.dog_min = bus_i.wdata;
      end else if (bus_i.addr == A_DOGMAX) begin
        s_next.dog_max = bus_i.wdata;
      end else if (bus_i.addr == A_PWMH) begin
        s_next.pwm_h = bus_i.wdata;
      end else if (bus_i.addr == A_PWML) begin
        s_next.pwm_l = bus_i.wdata;
      end else if (bus_i.addr == A_PWMD) begin
        s_next.pwm_div = bus_i.wdata;
      end else if (bus_i.addr == A_DOGTRIG) begin
        dog_trig = bus_i.wdata[0];
      end else if (bus_i.addr >= A_ONOFF && bus_i.addr < A_ONOFF + 8'(NREG)) begin
        idx = bus_i.addr - A_ONOFF;
        s_next.onoff_sel[idx[3:0]] = bus_i.wdata[2:0];
      end else if (bus_i.addr >= A_SINKC && bus_i.addr < A_SINKC + 8'(NSINK)) begin
        idx = bus_i.addr - A_SINKC;
        s_next.sink_ctrl[idx[1:0]] = bus_i.wdata[1:0];
      end else if (bus_i.addr >= A_SINKI && bus_i.addr < A_SINKI + 8'(NSINK)) begin
        idx = bus_i.addr - A_SINKI;
        s_next.sink_cur[idx[1:0]] = bus_i.wdata;
      end else if (bus_i.addr >= A_ALTC && bus_i.addr < A_ALTC + 8'(NSEL)) begin
        idx = bus_i.addr - A_ALTC;
        s_next.alt_choice[idx[1:0]] = bus_i.wdata[3:0];
      end else if (bus_i.addr >= A_ALTV && bus_i.addr < A_ALTV + 8'(NSEL)) begin
        idx = bus_i.addr - A_ALTV;
        s_next.alt_volt[idx[1:0]] = bus_i.wdata[6:0];
      end else if (bus_i.addr >= A_MASK && bus_i.addr < A_MASK + 8'(NFLAG)) begin
        idx = bus_i.addr - A_MASK;
        s_next.mask[idx[1:0]] = bus_i.wdata;
      end
    end else if (bus_i.rd) begin
      if (bus_i.addr >= A_CFG && bus_i.addr < A_CFG + 8'(NPIN)) begin
        idx = bus_i.addr - A_CFG;
        s_next.rdata = s_reg.cfg[idx[1:0]];
      end else if (bus_i.addr == A_PULL) begin
        s_next.rdata = {s_reg.pull_down, s_reg.pull_up};
      end else if (bus_i.addr == A_DRIVE) begin
        s_next.rdata = {4'h0, s_reg.drive};
      end else if (bus_i.addr == A_LEVEL) begin
        s_next.rdata = {4'h0, lvl};
      end else if (bus_i.addr == A_CTRL) begin
        s_next.rdata = {5'h00, s_reg.dog_rst_en, s_reg.dog_en, s_reg.supply_reset_enable};
      end else if (bus_i.addr == A_DOGMIN) begin
        s_next.rdata = s_reg.dog_min;
      end else if (bus_i.addr == A_DOGMAX) begin
        s_next.rdata = s_reg.dog_max;
      end else if (bus_i.addr == A_PWMH) begin
        s_next.rdata = s_reg.pwm_h;
      end else if (bus_i.addr == A_PWML) begin
        s_next.rdata = s_reg.pwm_l;
      end else if (bus_i.addr == A_PWMD) begin
        s_next.rdata = s_reg.pwm_div;
      end else if (bus_i.addr == A_STATUS) begin
        s_next.rdata = {5'h00, pwm, s_reg.dog_st};
      end else if (bus_i.addr >= A_ONOFF && bus_i.addr < A_ONOFF + 8'(NREG)) begin
        idx = bus_i.addr - A_ONOFF;
        s_next.rdata = {5'h00, s_reg.onoff_sel[idx[3:0]]};
      end else if (bus_i.addr >= A_SINKC && bus_i.addr < A_SINKC + 8'(NSINK)) begin
        idx = bus_i.addr - A_SINKC;
        s_next.rdata = {6'h00, s_reg.sink_ctrl[idx[1:0]]};
      end else if (bus_i.addr >= A_SINKI && bus_i.addr < A_SINKI + 8'(NSINK)) begin
        idx = bus_i.addr - A_SINKI;
        s_next.rdata = s_reg.sink_cur[idx[1:0]];
      end else if (bus_i.addr >= A_ALTC && bus_i.addr < A_ALTC + 8'(NSEL)) begin
        idx = bus_i.addr - A_ALTC;
        s_next.rdata = {4'h0, s_reg.alt_choice[idx[1:0]]};
      end else if (bus_i.addr >= A_ALTV && bus_i.addr < A_ALTV + 8'(NSEL)) begin
        idx = bus_i.addr - A_ALTV;
        s_next.rdata = {1'b0, s_reg.alt_volt[idx[1:0]]};
      end else if (flag_rd) begin
        idx = bus_i.addr - A_FLAG;
        if (s_reg.clr_cnt[idx[1:0]] == 2'h0) begin
          s_next.rdata = s_reg.flag[idx[1:0]];
          s_next.cap[idx[1:0]] = s_reg.flag[idx[1:0]];
          s_next.clr_cnt[idx[1:0]] = CLR_START;
        end
      end else if (bus_i.addr >= A_MASK && bus_i.addr < A_MASK + 8'(NFLAG)) begin
        idx = bus_i.addr - A_MASK;
        s_next.rdata = s_reg.mask[idx[1:0]];
      end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    for (int p = 0; p < NPIN; p++) begin
      if (s_reg.cfg[p].func == FN_DOG_IN && lvl[p] && !s_reg.lvl_prev[p]) begin
        dog_trig = 1'b1;
      end
    end
    s_next.dog_exp = 1'b0;
    s_next.dog_rst = 1'b0;
    if (!s_reg.dog_en) begin
      s_next.dog_st = DOG_OFF;
      s_next.dog_pre = '0;
      s_next.dog_cnt = '0;
    end else begin
      if (s_reg.dog_pre >= 32'(DOG_TICK - 1)) begin
        s_next.dog_pre = '0;
        s_next.dog_cnt = s_reg.dog_cnt + 8'h01;
      end else begin
        s_next.dog_pre = s_reg.dog_pre + 32'h1;
      end
      // Early trigger counts as a miss, like a timeout
      if ((dog_trig && s_reg.dog_cnt < s_reg.dog_min) ||
          (!dog_trig && s_reg.dog_cnt >= s_reg.dog_max)) begin
        s_next.dog_exp = 1'b1;
        s_next.dog_rst = s_reg.dog_rst_en;
        s_next.dog_pre = '0;
        s_next.dog_cnt = '0;
      end else if (dog_trig) begin
        s_next.dog_pre = '0;
        s_next.dog_cnt = '0;
      end
      if (s_next.dog_cnt < s_reg.dog_min) begin
        s_next.dog_st = DOG_CLOSED;
      end else begin
        s_next.dog_st = DOG_OPEN;
      end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    for (int p = 0; p < NPIN; p++) begin
      case (s_reg.cfg[p].func)
        FN_IRQ_OUT: val[p] = irq;
        FN_SUP_LOW: val[p] = supply_fall_threshold_i && !s_reg.supply_reset_enable;
        FN_PGOOD: val[p] = startup_done_i;
        FN_SLOWCLK: val[p] = xtal_ok_i ? xtal_clk_i : rc_clk_i;
        FN_BOOST_OC: val[p] = first_boost_converter_oc_i;
        FN_PWM_OUT: val[p] = pwm;
        default: val[p] = s_reg.drive[p];
      endcase
      if (s_reg.cfg[p].pwm_src) begin
        val[p] = pwm;
      end
      val[p] = val[p] ^ s_reg.cfg[p].invert;
      s_next.pad_out[p] = val[p];
      s_next.ana[p] = 1'b0;
      case (s_reg.cfg[p].mode)
        MD_PP: s_next.pad_oe_n[p] = 1'b0;
        MD_OD: s_next.pad_oe_n[p] = val[p];
        MD_ANA: begin
          s_next.pad_oe_n[p] = 1'b1;
          // Pin zero has no analog path
          s_next.ana[p] = (p != 0);
        end
        default: s_next.pad_oe_n[p] = 1'b1;
      endcase
    end

    // ----------------------------------------
    // Regulator, sink and stand-by control
    // ----------------------------------------
    for (int r = 0; r < NREG; r++) begin
      idx = {5'h00, s_reg.onoff_sel[r]};
      s_next.reg_ctrl[r] = (idx != 8'h00) && (idx <= 8'(NPIN));
      s_next.reg_on[r] = 1'b0;
      if (s_next.reg_ctrl[r]) begin
        s_next.reg_on[r] = lvl[idx[1:0] - 2'h1];
      end
    end
    dim = 1'b0;
    for (int p = 0; p < NPIN; p++) begin
      if (s_reg.cfg[p].func == FN_DIM_IN && lvl[p]) begin
        dim = 1'b1;
      end
    end
    for (int k = 0; k < NSINK; k++) begin
      if (s_reg.sink_ctrl[k] == SINK_DIM) begin
        s_next.sink_on[k] = dim;
      end else begin
        s_next.sink_on[k] = (s_reg.sink_ctrl[k] != 2'h0);
      end
    end
    s_next.alt = vsel_map(FN_VSEL, lvl, s_reg.cfg) | vsel_map(FN_STBY, lvl, s_reg.cfg);
    s_next.standby = |vsel_map(FN_STBY, lvl, s_reg.cfg);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.pad_oe_n <= '1;
      s_reg.pwm_h <= PWMH_RST;
      s_reg.pwm_l <= PWML_RST;
      s_reg.dog_max <= DOGMAX_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign pad_o = s_reg.pad_out;
  assign pad_oe_n_o = s_reg.pad_oe_n;
  assign pull_up_o = s_reg.pull_up;
  assign pull_down_o = s_reg.pull_down;
  assign analog_en_o = s_reg.ana;
  assign reg_pin_ctrl_o = s_reg.reg_ctrl;
  assign reg_pin_on_o = s_reg.reg_on;
  assign sink_on_o = s_reg.sink_on;
  assign sink_current_level_o = s_reg.sink_cur;
  assign alt_active_o = s_reg.alt;
  assign alternate_regulator_choice_o = s_reg.alt_choice;
  assign alternate_voltage_setting_o = s_reg.alt_volt;
  assign standby_req_o = s_reg.standby;
  assign dog_expired_o = s_reg.dog_exp;
  assign dog_reset_req_o = s_reg.dog_rst;
endmodule : pgf_gpio

/* pgf_pkg.sv */
package pgf_pkg;
  localparam int NPIN = 4;
  localparam int NREG = 11;
  localparam int NSEL = 3;
  localparam int NSINK = 3;
  localparam int NFLAG = 3;
  // ----------------------------------------
  // Pin function codes
  // ----------------------------------------
  localparam logic [3:0] FN_NORMAL = 4'h0;
  localparam logic [3:0] FN_IRQ_OUT = 4'h1;
  localparam logic [3:0] FN_SUP_LOW = 4'h2;
  localparam logic [3:0] FN_IRQ_IN = 4'h3;
  localparam logic [3:0] FN_DIM_IN = 4'h4;
  localparam logic [3:0] FN_VSEL = 4'h5;
  localparam logic [3:0] FN_STBY = 4'h6;
  localparam logic [3:0] FN_PGOOD = 4'h7;
  localparam logic [3:0] FN_SLOWCLK = 4'h8;
  localparam logic [3:0] FN_DOG_IN = 4'h9;
  localparam logic [3:0] FN_BOOST_OC = 4'ha;
  localparam logic [3:0] FN_PWM_OUT = 4'hb;
  localparam logic [1:0] MD_IN = 2'h0;
  localparam logic [1:0] MD_PP = 2'h1;
  localparam logic [1:0] MD_OD = 2'h2;
  localparam logic [1:0] MD_ANA = 2'h3;
  localparam logic [1:0] SINK_DIM = 2'h3;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_PULL = 8'h04;
  localparam logic [7:0] A_DRIVE = 8'h05;
  localparam logic [7:0] A_LEVEL = 8'h06;
  localparam logic [7:0] A_CTRL = 8'h07;
  localparam logic [7:0] A_DOGMIN = 8'h08;
  localparam logic [7:0] A_DOGMAX = 8'h09;
  localparam logic [7:0] A_PWMH = 8'h0a;
  localparam logic [7:0] A_PWML = 8'h0b;
  localparam logic [7:0] A_PWMD = 8'h0c;
  localparam logic [7:0] A_DOGTRIG = 8'h0d;
  localparam logic [7:0] A_STATUS = 8'h0e;
  localparam logic [7:0] A_ONOFF = 8'h10;
  localparam logic [7:0] A_SINKC = 8'h20;
  localparam logic [7:0] A_SINKI = 8'h24;
  localparam logic [7:0] A_ALTC = 8'h28;
  localparam logic [7:0] A_ALTV = 8'h2c;
  localparam logic [7:0] A_FLAG = 8'h30;
  localparam logic [7:0] A_MASK = 8'h34;
  localparam logic [7:0] PWMH_RST = 8'h01;
  localparam logic [7:0] PWML_RST = 8'h01;
  localparam logic [7:0] DOGMAX_RST = 8'hff;
  localparam logic [1:0] CLR_START = 2'h3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int DOG_TICK_NS = 1000000;
  localparam int DOG_TICK_CYC = DOG_TICK_NS / CLK_PERIOD_NS;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgf_bus_req_t;
  typedef struct packed {
    logic pwm_src;
    logic invert;
    logic [1:0] mode;
    logic [3:0] func;
  } pgf_pin_cfg_t;
  typedef enum logic [1:0] {
    DOG_OFF = 2'b00,
    DOG_CLOSED = 2'b01,
    DOG_OPEN = 2'b10
  } pgf_dog_st_t;
endpackage : pgf_pkg

/* pgf_pwm.sv */
`timescale 1ns/1ps
module pgf_pwm #(
  parameter int W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] high_i,
  input wire logic [W-1:0] low_i,
  input wire logic [W-1:0] div_i,
  output logic pwm_o
);
  import pgf_pkg::*;
  typedef struct packed {
    logic [W-1:0] pre;
    logic [W:0] phase;
    logic level;
  } pgf_pwm_st_t;
  pgf_pwm_st_t s_reg, s_next;
  logic [W:0] period;

  always_comb begin
    period = {1'b0, high_i} + {1'b0, low_i};
    s_next = s_reg;
    if (s_reg.pre >= div_i) begin
      s_next.pre = '0;
      // One period is high time plus low time
      if (s_reg.phase + 1'b1 >= period) begin
        s_next.phase = '0;
      end else begin
        s_next.phase = s_reg.phase + 1'b1;
      end
    end else begin
      s_next.pre = s_reg.pre + 1'b1;
    end
    s_next.level = (s_next.phase < {1'b0, high_i});
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pwm_o = s_reg.level;
endmodule : pgf_pwm

/* pgf_pin_env.sv */
`timescale 1ns/1ps
module pgf_pin_env (
  input wire logic mclk_i,
  input wire logic [3:0] pad_o,
  input wire logic [3:0] pad_oe_n_o,
  input wire logic [3:0] pull_up_o,
  input wire logic [3:0] pull_down_o,
  input wire logic [3:0] ext_lvl_i,
  input wire logic [3:0] ext_en_i,
  output logic [3:0] pad_i
);
  // Floating pins toggle so no stale level reads as valid
  logic [3:0] float_q = 4'h0;
  always_ff @(posedge mclk_i) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pad_oe_n_o[i]) begin
        pad_i[i] = pad_o[i];
      end else if (ext_en_i[i]) begin
        pad_i[i] = ext_lvl_i[i];
      end else if (pull_up_o[i] || pull_down_o[i]) begin
        pad_i[i] = pull_up_o[i];
      end else begin
        pad_i[i] = float_q[i];
      end
    end
  end
endmodule : pgf_pin_env

/* pgf_gpio_chk_sva.sv */
`timescale 1ns/1ps
module pgf_gpio_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pgf_pkg::pgf_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic [pgf_pkg::NPIN-1:0] pad_o,
  input wire logic [pgf_pkg::NPIN-1:0] pad_oe_n_o,
  input wire logic [pgf_pkg::NPIN-1:0] analog_en_o,
  input wire logic first_boost_converter_oc_i,
  input wire logic dog_expired_o,
  input wire logic dog_reset_req_o
);
  import pgf_pkg::*;
  // Shadow of pin configs; masks lag one cycle like the pads
  logic [3:0][7:0] cfg;
  logic [3:0] in_m;
  logic [3:0] pp_m;
  logic flag_rd;
  logic irq0;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= '0;
      in_m <= '0;
      pp_m <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        in_m[i] <= cfg[i][5] == cfg[i][4];
        pp_m[i] <= cfg[i][5:4] == MD_PP;
      end
      if (bus_i.wr && bus_i.addr < 8'h04) begin
        cfg[bus_i.addr[1:0]] <= bus_i.wdata;
      end
    end
  end
  assign flag_rd = bus_i.rd && bus_i.addr == A_FLAG;
  assign irq0 = cfg[0] == 8'h11;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside slot");
  chk_reread_zero: assert property (flag_rd ##1 flag_rd |=> rdata_o == 8'h00)
    else $error("flag reread not zero");
  chk_irq_release: assert property (irq0 && flag_rd |-> ##2 (!pad_o[0]) [*2])
    else $error("request not released");
  chk_analog_pin0: assert property (!analog_en_o[0])
    else $error("analog on first pin");
  chk_input_undriven: assert property ((pad_oe_n_o & in_m) == in_m)
    else $error("input pin driven");
  chk_pushpull_drive: assert property ((pad_oe_n_o & pp_m) == 4'h0)
    else $error("push-pull pin not driven");
  chk_oc_follow: assert property (cfg[0] == 8'h1a && $rose(first_boost_converter_oc_i)
    |-> ##[1:3] pad_o[0]) else $error("over-current not shown");
  chk_reset_pair: assert property (dog_reset_req_o |-> dog_expired_o)
    else $error("reset without expiry");
  chk_expire_pulse: assert property (dog_expired_o |=> !dog_expired_o)
    else $error("expiry not a pulse");
  cover property (flag_rd ##1 flag_rd);
  cover property (irq0 && flag_rd);
  cover property (dog_expired_o && dog_reset_req_o);
endmodule : pgf_gpio_chk

bind pgf_gpio pgf_gpio_chk pgf_gpio_chk_inst (
  .mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .pad_o(pad_o),
  .pad_oe_n_o(pad_oe_n_o), .analog_en_o(analog_en_o),
  .first_boost_converter_oc_i(first_boost_converter_oc_i),
  .dog_expired_o(dog_expired_o), .dog_reset_req_o(dog_reset_req_o));

/* pgf_gpio_bench.sv */
`timescale 1ns/1ps
module pgf_gpio_bench;
  import pgf_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  pgf_bus_req_t bus = '0;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [3:0] pad_i, pad_o, oe_n, pu, pd;
  logic [3:0] ext_lvl = 4'h0;
  logic [3:0] ext_en = 4'h0;
  logic [23:0] irq_ev = '0;
  logic oc = 1'b0;
  logic sup_low = 1'b0;
  logic pwr_ok = 1'b0;
  logic [2:0] alt_act;
  logic stby;
  logic exp_p, rreq_p;
  int fail_count = 0;
  int checked = 0;
  int exp_cnt = 0;
  int rreq_cnt = 0;
  always #2.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (exp_p === 1'b1) exp_cnt <= exp_cnt + 1;
    if (rreq_p === 1'b1) rreq_cnt <= rreq_cnt + 1;
  end
  pgf_gpio #(.DOG_TICK(4)) pgf_gpio_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_n_o(oe_n), .pull_up_o(pu), .pull_down_o(pd), .analog_en_o(),
    .irq_event_i(irq_ev), .supply_fall_threshold_i(sup_low), .startup_done_i(pwr_ok),
    .xtal_clk_i(1'b0), .xtal_ok_i(1'b1), .rc_clk_i(1'b0), .first_boost_converter_oc_i(oc),
    .reg_pin_ctrl_o(), .reg_pin_on_o(), .sink_on_o(), .sink_current_level_o(),
    .alt_active_o(alt_act), .alternate_regulator_choice_o(), .alternate_voltage_setting_o(),
    .standby_req_o(stby), .dog_expired_o(exp_p), .dog_reset_req_o(rreq_p));
  pgf_pin_env pgf_pin_env_inst (.mclk_i(mclk_i), .pad_o(pad_o), .pad_oe_n_o(oe_n),
    .pull_up_o(pu), .pull_down_o(pd), .ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pad_i(pad_i));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk_i);
    bus.wr <= 1'b0;
    // Idle edge so a following write never re-raises the strobe in the same step
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    @(posedge mclk_i);
    d = rdata;
  endtask : rd
  task automatic close_out;
    $display("checks=%0d errors=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  initial begin
    wt(20000);
    fail_count++;
    close_out();
  end
  initial begin
    wt(8);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(A_PWMH, got);
    check(got, PWMH_RST);
    rd(A_DOGMAX, got);
    check(got, DOGMAX_RST);
    rd(8'h3f, got);
    check(got, 8'h00);
    check({4'h0, oe_n}, 8'h0f);
    wr(A_CFG + 8'h03, 8'h10);
    wr(A_DRIVE, 8'h08);
    ext_en <= 4'h7;
    ext_lvl <= 4'h4;
    wt(6);
    check({4'h0, pad_o & 4'h8}, 8'h08);
    rd(A_LEVEL, got);
    check(got & 8'h07, 8'h04);
    wr(A_CFG + 8'h03, 8'h50);
    wr(A_CFG + 8'h02, 8'h40);
    wt(6);
    check({4'h0, pad_o & 4'h8}, 8'h00);
    rd(A_LEVEL, got);
    check(got & 8'h07, 8'h00);
    wr(A_CFG, 8'h11);
    wr(A_CFG + 8'h01, 8'h03);
    wr(A_MASK, 8'h01);
    ext_lvl <= 4'h6;
    wt(8);
    check({7'h0, pad_o[0]}, 8'h01);
    // Back-to-back flag reads: second lands inside the clear
    bus.rd <= 1'b1;
    bus.addr <= A_FLAG;
    wt(2);
    bus.rd <= 1'b0;
    check(rdata, 8'h01);
    wt(1);
    check(rdata, 8'h00);
    wt(6);
    check({7'h0, pad_o[0]}, 8'h00);
    irq_ev <= 24'h000200;
    wt(1);
    irq_ev <= '0;
    wt(4);
    check({7'h0, pad_o[0]}, 8'h00);
    rd(A_FLAG + 8'h01, got);
    check(got, 8'h02);
    ext_lvl <= 4'h4;
    wt(8);
    check({7'h0, pad_o[0]}, 8'h01);
    rd(A_FLAG, got);
    check(got, 8'h01);
    wr(A_CFG, 8'h1a);
    oc <= 1'b1;
    wt(4);
    check({7'h0, pad_o[0]}, 8'h01);
    oc <= 1'b0;
    wt(4);
    check({7'h0, pad_o[0]}, 8'h00);
    wr(A_CFG + 8'h03, 8'h12);
    sup_low <= 1'b1;
    wt(3);
    check({7'h0, pad_o[3]}, 8'h01);
    wr(A_CTRL, 8'h01);
    wt(3);
    check({7'h0, pad_o[3]}, 8'h00);
    wr(A_CFG + 8'h03, 8'h17);
    wt(3);
    check({7'h0, pad_o[3]}, 8'h00);
    pwr_ok <= 1'b1;
    wt(3);
    check({7'h0, pad_o[3]}, 8'h01);
    wr(A_CFG + 8'h02, 8'h06);
    ext_lvl <= 4'h0;
    wt(6);
    check({4'h0, alt_act, stby}, 8'h0f);
    ext_lvl <= 4'h4;
    wt(6);
    check({4'h0, alt_act, stby}, 8'h00);
    wr(A_CFG + 8'h01, 8'h09);
    wr(A_DOGMAX, 8'h08);
    wr(A_CTRL, 8'h06);
    repeat (4) begin
      wt(12);
      ext_lvl <= 4'h6;
      wt(4);
      ext_lvl <= 4'h4;
    end
    check(8'(exp_cnt), 8'h00);
    for (int i = 0; i < 200 && exp_cnt == 0; i++) begin
      @(posedge mclk_i);
    end
    check({7'h0, exp_cnt > 0}, 8'h01);
    check(8'(rreq_cnt), 8'(exp_cnt));
    close_out();
  end
endmodule : pgf_gpio_bench
